// File: rtl/mtc_params.svh
// Constants of the multihit time capture block
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define MTC_CH_NUM       96
`define MTC_CH_PER_UNIT  8
`define MTC_TIME_W       16
`define MTC_FINE_W       4
`define MTC_LIFO_MAX     16
`define MTC_EVT_SLOTS    7
`define MTC_TAG_W        3
`define MTC_FIFO_DEPTH   8
`define MTC_MEM_WORDS    512
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MTC_CLK_PS       8000
`define MTC_LSB_PS       500
`define MTC_FS_STEP_NS   8
`define MTC_CW_UNIT_NS   1024
`define MTC_CW_UNIT_CYC  ((`MTC_CW_UNIT_NS * 1000) / `MTC_CLK_PS)
`define MTC_TP_HP0_NS    125
`define MTC_TP_HP1_NS    250
`define MTC_TP_HP2_NS    1000
`define MTC_TP_HP3_NS    2000
`define MTC_NS2CYC(n)    (((n) * 1000) / `MTC_CLK_PS)
// ----------------------------------------------------------------
// Output word layout
// ----------------------------------------------------------------
`define MTC_WORD_HDR_BIT 31
`define MTC_HDR_TAG_LSB  28
`define MTC_DAT_CH_LSB   24
`define MTC_DAT_EDGE_BIT 16
`endif

// File: rtl/mtc_pkg.sv
// Types of the multihit time capture block
package mtc_pkg;
   typedef enum logic [1:0] {
      EDGE_RISING,
      EDGE_FALLING,
      EDGE_BOTH
   } mtc_edge_type;
   typedef enum logic {
      MODE_COMMON_START,
      MODE_COMMON_STOP
   } mtc_mode_type;
   typedef enum {
      ST_IDLE,
      ST_ACQ,
      ST_CLEARWIN,
      ST_CONV
   } mtc_state_type;
endpackage

// File: rtl/mtc_fifo.sv
// Output word FIFO with valid and ready on both sides
module mtc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rptr];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end else begin
         if (push) wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
         if (pop) rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem[wptr] <= in_data;
   end
endmodule

// File: rtl/mtc_capture.sv
// Multihit time capture, conversion and event buffering
`include "mtc_params.svh"

module mtc_capture
   import mtc_pkg::*;
#(
   parameter int CH_NUM    = `MTC_CH_NUM,
   parameter int MEM_WORDS = `MTC_MEM_WORDS,
   parameter int FIFO_DEPTH = `MTC_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // Channel and common inputs
   input  wire logic [CH_NUM-1:0]       hit_in,
   input  wire logic [CH_NUM*4-1:0]     hit_fine,
   input  wire logic                    common_in,
   input  wire logic [3:0]              common_fine,
   input  wire logic                    time_out,
   input  wire logic                    fast_clear,
   // Configuration
   input  wire mtc_mode_type            mode,
   input  wire mtc_edge_type            edge_mode,
   input  wire logic [4:0]              lifo_depth,
   input  wire logic [12:0]             full_scale,
   input  wire logic                    ext_time_out,
   input  wire logic [9:0]              clear_window,
   // Test pulser
   input  wire logic                    test_enable,
   input  wire logic                    test_go,
   input  wire logic [1:0]              test_cycles,
   input  wire logic [1:0]              test_period,
   // Readout
   output logic                         out_valid,
   input  wire logic                    out_ready,
   output logic [31:0]                  out_data,
   input  wire logic                    skip_event,
   // Status
   output logic                         busy,
   output logic                         available,
   output logic [2:0]                   events_stored
);
   localparam int AW = $clog2(MEM_WORDS);
   localparam int CW = $clog2(CH_NUM);
   localparam logic [8:0] HP0 = 9'(`MTC_NS2CYC(`MTC_TP_HP0_NS));
   localparam logic [8:0] HP1 = 9'(`MTC_NS2CYC(`MTC_TP_HP1_NS));
   localparam logic [8:0] HP2 = 9'(`MTC_NS2CYC(`MTC_TP_HP2_NS));
   localparam logic [8:0] HP3 = 9'(`MTC_NS2CYC(`MTC_TP_HP3_NS));
   localparam logic [19:0] CW_UNIT = 20'(`MTC_CW_UNIT_CYC);

   // Returns a wrapped index into the programmed ring
   function automatic logic [3:0] ring_idx(input logic [3:0] wp,
                                           input logic [4:0] k,
                                           input logic [4:0] dep);
      logic [5:0] t;
      t = {2'b00, wp} + {1'b0, dep} - {1'b0, k} - 6'd1;
      if ({1'b0, k} < {2'b00, wp}) ring_idx = 4'(wp - k[3:0] - 4'd1);
      else ring_idx = t[3:0];
   endfunction

   // ----------------------------------------------------------------
   // Time base and test pulser
   // ----------------------------------------------------------------
   mtc_state_type state;
   logic [11:0] coarse;
   logic        test_level;
   logic [8:0]  tp_cnt;
   logic [4:0]  tp_halves;
   logic [8:0]  tp_half;

   // One clock is sixteen 500 ps counts; fine bits fill the rest
   always_ff @(posedge clk) begin
      if (!rstn) coarse <= 12'h000;
      else coarse <= coarse + 12'h001;
   end

   always_comb begin
      unique case (test_period)
         2'd0: tp_half = HP0;
         2'd1: tp_half = HP1;
         2'd2: tp_half = HP2;
         2'd3: tp_half = HP3;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         test_level <= 1'b0;
         tp_cnt     <= 9'h000;
         tp_halves  <= 5'h00;
      end else if (test_go && test_enable && tp_halves == 5'h00) begin
         test_level <= 1'b1;
         tp_cnt     <= 9'h001;
         tp_halves  <= 5'(({3'b000, 2'b01} << test_cycles) << 1) - 5'h01;
      end else if (tp_halves != 5'h00) begin
         if (tp_cnt == tp_half) begin
            tp_cnt     <= 9'h001;
            tp_halves  <= tp_halves - 5'h01;
            test_level <= ~test_level;
         end else begin
            tp_cnt <= tp_cnt + 9'h001;
         end
      end else begin
         test_level <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection per channel
   // ----------------------------------------------------------------
   logic [CH_NUM-1:0] ch_level;
   logic [CH_NUM-1:0] ch_prev;
   logic [CH_NUM-1:0] ch_rise;
   logic [CH_NUM-1:0] ch_fall;
   logic [CH_NUM-1:0] ch_hit;
   logic              accept_hits;

   // Test pulses are ORed in so the whole capture path is exercised
   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++) begin : g_edge
         assign ch_level[g] = hit_in[g] | (test_enable & test_level);
         assign ch_rise[g]  = ch_level[g] & ~ch_prev[g];
         assign ch_fall[g]  = ~ch_level[g] & ch_prev[g];
         assign ch_hit[g]   = accept_hits &
            ((ch_rise[g] & (edge_mode != EDGE_FALLING)) |
             (ch_fall[g] & (edge_mode != EDGE_RISING)));
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rstn) ch_prev <= '0;
      else ch_prev <= ch_level;
   end

   // ----------------------------------------------------------------
   // Per-channel hit stores
   // ----------------------------------------------------------------
   logic [16:0] hit_mem [CH_NUM][`MTC_LIFO_MAX];
   logic [3:0]  hit_wp  [CH_NUM];
   logic [4:0]  hit_cnt [CH_NUM];
   logic [4:0]  depth;
   logic        clr_stores;

   // Programmed depth is clamped to 1..16 entries per channel store
   assign depth = (lifo_depth == 5'h00) ? 5'h01 :
                  (lifo_depth > 5'h10) ? 5'h10 : lifo_depth;

   // Ring of programmed depth: oldest hit is overwritten when full
   always_ff @(posedge clk) begin
      if (!rstn || clr_stores) begin
         for (int c = 0; c < CH_NUM; c++) begin
            hit_wp[c]  <= 4'h0;
            hit_cnt[c] <= 5'h00;
         end
      end else begin
         for (int c = 0; c < CH_NUM; c++) begin
            if (ch_hit[c]) begin
               hit_wp[c] <= (5'(hit_wp[c]) + 5'h01 >= depth) ? 4'h0 :
                            hit_wp[c] + 4'h1;
               if (hit_cnt[c] < depth) hit_cnt[c] <= hit_cnt[c] + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int c = 0; c < CH_NUM; c++) begin
         if (ch_hit[c])
            hit_mem[c][hit_wp[c]] <= {ch_fall[c], coarse,
                                      hit_fine[c*4 +: 4]};
      end
   end

   // ----------------------------------------------------------------
   // Event sequencing
   // ----------------------------------------------------------------
   logic [15:0]   ref_time;
   logic [12:0]   acq_cnt;
   logic [19:0]   cw_cnt;
   logic          fc_prev;
   logic          fc_edge;
   logic          acq_end;
   logic [CW-1:0] cv_ch;
   logic [4:0]    cv_k;
   logic          cv_last;
   logic [2:0]    ev_count;
   logic          mem_room;

   assign fc_edge = fast_clear & ~fc_prev;
   assign acq_end = ext_time_out ? time_out :
                    (acq_cnt >= full_scale);
   assign accept_hits = (mode == MODE_COMMON_START) ?
                        (state == ST_ACQ && !acq_end) :
                        (state == ST_IDLE);
   assign cv_last = (cv_ch == CW'(CH_NUM-1)) && (cv_k >= hit_cnt[cv_ch]);
   assign available = (state == ST_IDLE) &&
                      (ev_count < 3'(`MTC_EVT_SLOTS)) && mem_room;
   assign busy = (state == ST_CONV) || !available;
   assign clr_stores = (state == ST_CLEARWIN && fc_edge) ||
                       (state == ST_CONV && cv_last) ||
                       (state == ST_IDLE && common_in && available &&
                        mode == MODE_COMMON_START);

   always_ff @(posedge clk) begin
      if (!rstn) fc_prev <= 1'b0;
      else fc_prev <= fast_clear;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state    <= ST_IDLE;
         ref_time <= 16'h0000;
         acq_cnt  <= 13'h0000;
         cw_cnt   <= 20'h00000;
         cv_ch    <= '0;
         cv_k     <= 5'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (common_in && available) begin
                  ref_time <= {coarse, common_fine};
                  acq_cnt  <= 13'h0001;
                  cw_cnt   <= 20'h00001;
                  state    <= (mode == MODE_COMMON_START) ? ST_ACQ :
                              ST_CLEARWIN;
               end
            end
            ST_ACQ: begin
               acq_cnt <= acq_cnt + 13'h0001;
               if (acq_end) state <= ST_CLEARWIN;
            end
            ST_CLEARWIN: begin
               cw_cnt <= cw_cnt + 20'h00001;
               if (fc_edge) state <= ST_IDLE;
               else if (cw_cnt >= 20'(clear_window) * CW_UNIT) begin
                  state <= ST_CONV;
                  cv_ch <= '0;
                  cv_k  <= 5'h00;
               end
            end
            ST_CONV: begin
               if (cv_last) state <= ST_IDLE;
               else if (cv_k < hit_cnt[cv_ch]) cv_k <= cv_k + 5'h01;
               else begin
                  cv_k  <= 5'h00;
                  cv_ch <= cv_ch + CW'(1);
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Conversion into event memory
   // ----------------------------------------------------------------
   logic [31:0]   ev_mem [MEM_WORDS];
   logic [AW-1:0] ev_wptr;
   logic [AW-1:0] hdr_addr;
   logic [10:0]   n_words;
   logic [AW:0]   mem_used;
   logic [AW:0]   next_mem_used;
   logic [16:0]   cv_entry;
   logic [15:0]   cv_diff;
   logic          cv_keep;
   logic          cv_step;
   logic          commit;
   logic [2:0]    tag;
   logic [AW-1:0] slot_start [8];
   logic [10:0]   slot_len   [8];
   logic [2:0]    tail;
   logic [2:0]    head;
   logic          release_head;

   assign cv_step  = (state == ST_CONV) && (cv_k < hit_cnt[cv_ch]);
   assign cv_entry = hit_mem[cv_ch][ring_idx(hit_wp[cv_ch], cv_k, depth)];
   assign cv_diff  = (mode == MODE_COMMON_STOP) ?
                     ref_time - cv_entry[15:0] :
                     cv_entry[15:0] - ref_time;
   assign cv_keep  = cv_step && ({1'b0, cv_diff} <= {full_scale, 4'h0}) &&
                     ((mem_used + (AW+1)'(n_words) + (AW+1)'(2)) <
                      (AW+1)'(MEM_WORDS));
   assign commit   = (state == ST_CONV) && cv_last;
   assign mem_room = (mem_used + (AW+1)'(2)) < (AW+1)'(MEM_WORDS);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ev_wptr  <= '0;
         hdr_addr <= '0;
         n_words  <= 11'h000;
         tag      <= 3'h0;
         tail     <= 3'h0;
      end else if (state == ST_CLEARWIN && !fc_edge &&
                   cw_cnt >= 20'(clear_window) * CW_UNIT) begin
         hdr_addr <= ev_wptr;
         ev_wptr  <= ev_wptr + AW'(1);
         n_words  <= 11'h000;
      end else if (cv_keep) begin
         ev_wptr <= ev_wptr + AW'(1);
         n_words <= n_words + 11'h001;
      end else if (commit) begin
         slot_start[tail] <= hdr_addr;
         slot_len[tail]   <= n_words + 11'h001;
         tail             <= tail + 3'h1;
         tag              <= tag + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (cv_keep)
         ev_mem[ev_wptr] <= {1'b0, 7'(cv_ch), 7'h00, cv_entry[16],
                             cv_diff};
      else if (commit)
         ev_mem[hdr_addr] <= {1'b1, tag, 17'h00000,
                              n_words};
   end

   // ----------------------------------------------------------------
   // Event buffer readout
   // ----------------------------------------------------------------
   logic [10:0] rd_off;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [31:0] fifo_in_data;

   // Readout pulls the head event while later events are still taken
   assign fifo_in_valid = (ev_count != 3'h0) && !skip_event;
   assign fifo_in_data  = ev_mem[slot_start[head] + AW'(rd_off)];
   assign release_head  = (ev_count != 3'h0) &&
      (skip_event || (fifo_in_ready &&
                      rd_off == slot_len[head] - 11'h001));

   assign next_mem_used = mem_used
      + (commit ? (AW+1)'(n_words + 11'h001) : '0)
      - (release_head ? (AW+1)'(slot_len[head]) : '0);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         head     <= 3'h0;
         rd_off   <= 11'h000;
         ev_count <= 3'h0;
         mem_used <= '0;
      end else begin
         mem_used <= next_mem_used;
         ev_count <= ev_count + 3'(commit) - 3'(release_head);
         if (release_head) begin
            head   <= head + 3'h1;
            rd_off <= 11'h000;
         end else if (fifo_in_valid && fifo_in_ready) begin
            rd_off <= rd_off + 11'h001;
         end
      end
   end

   assign events_stored = ev_count;

   mtc_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );
endmodule

// File: bench/mtc_capture_asserts.sv
// Port-level assertions for the multihit time capture block
module mtc_capture_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Watched ports
   input wire logic        common_in,
   input wire logic        skip_event,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [31:0] out_data,
   input wire logic        busy,
   input wire logic        available,
   input wire logic [2:0]  events_stored
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       seen;
   logic       skipped;
   logic [2:0] last_tag;
   logic       pop_hdr;
   assign pop_hdr = out_valid && out_ready && out_data[31];
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----
   // Header tracking
   // ----
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seen <= 1'b0;
      end else if (pop_hdr) begin
         seen <= 1'b1;
      end
   end
   // A skip may remove a header never seen, so the next tag step is excused
   always_ff @(posedge clk) begin
      if (!rstn || pop_hdr) begin
         skipped <= 1'b0;
      end else if (skip_event) begin
         skipped <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (pop_hdr) begin
         last_tag <= out_data[30:28];
      end
   end
   // ----
   // Assertions
   // ----
   a_hold_word: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output word changed while stalled");
   a_first_header: assert property (
      out_valid && !seen |-> out_data[31])
      else $error("first word after reset is not a header");
   a_tag_step: assert property (
      pop_hdr && seen && !skipped |-> out_data[30:28] == last_tag + 3'd1)
      else $error("event tag did not advance by one");
   a_data_channel: assert property (
      out_valid && !out_data[31] |-> out_data[30:24] < 7'd96)
      else $error("data word channel out of range");
   a_count_step: assert property (
      1'b1 |=> events_stored == $past(events_stored)
         || events_stored == $past(events_stored) + 3'd1
         || events_stored == $past(events_stored) - 3'd1)
      else $error("event count jumped by more than one");
   a_full_shut: assert property (
      events_stored == 3'd7 |-> !available)
      else $error("available while all slots hold events");
   a_busy_avail: assert property (
      busy == !available)
      else $error("busy and available disagree");
   a_common_take: assert property (
      available && common_in |=> !available [*8])
      else $error("common signal did not close capture");
   c_full: cover property (events_stored == 3'd7);
   c_skip: cover property (skip_event && out_valid);
   c_data: cover property (pop_hdr && out_data[10:0] != 11'h0);
endmodule

bind mtc_capture mtc_capture_chk u_chk (
   .clk(clk), .rstn(rstn), .common_in(common_in), .skip_event(skip_event),
   .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
   .busy(busy), .available(available), .events_stored(events_stored)
);

// File: bench/mtc_reader.sv
// Readout master model: drains words, stalls on demand, issues skips
module mtc_reader (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Readout side of the block
   input  wire logic        out_valid,
   output logic             out_ready,
   input  wire logic [31:0] out_data,
   output logic             skip_event,
   // Bench side
   input  wire logic        stall,
   input  wire logic        skip_req,
   output logic             got,
   output logic [31:0]      word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] pace;
   // One slow cycle in four, so the drain is not always prompt
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pace      <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         pace      <= pace + 2'h1;
         out_ready <= !stall && pace != 2'h3;
      end
   end
   always_ff @(posedge clk) begin
      got  <= rstn && out_valid && out_ready;
      word <= out_data;
   end
   always_ff @(posedge clk) begin
      skip_event <= rstn && skip_req;
   end
endmodule

// File: bench/tb.sv
// Self-checking bench for the multihit time capture block
module tb
   import mtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
   logic         clk = 1'b0;
   logic         rstn;
   logic [95:0]  hit_in;
   logic [383:0] hit_fine;
   logic [3:0]   common_fine, cf;
   logic         common_in, time_out, fast_clear, ext_time_out;
   mtc_mode_type mode;
   mtc_edge_type edge_mode;
   logic [4:0]   lifo_depth;
   logic [12:0]  full_scale;
   logic [9:0]   clear_window;
   logic         test_enable, test_go, stall, skip_req, got;
   logic [1:0]   test_cycles, test_period;
   logic         out_valid, out_ready, skip_event, busy, available;
   logic [31:0]  out_data, word;
   logic [2:0]   events_stored, tag;
   logic [63:0]  exp_q[$];
   logic [63:0]  note;
   int           bad_count, checks_done, seed;

   always #4 clk = ~clk;

   mtc_capture dut (
      .clk(clk), .rstn(rstn), .hit_in(hit_in), .hit_fine(hit_fine),
      .common_in(common_in), .common_fine(common_fine),
      .time_out(time_out), .fast_clear(fast_clear), .mode(mode),
      .edge_mode(edge_mode), .lifo_depth(lifo_depth),
      .full_scale(full_scale), .ext_time_out(ext_time_out),
      .clear_window(clear_window), .test_enable(test_enable),
      .test_go(test_go), .test_cycles(test_cycles),
      .test_period(test_period), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data),
      .skip_event(skip_event), .busy(busy), .available(available),
      .events_stored(events_stored)
   );
   mtc_reader partner (
      .clk(clk), .rstn(rstn), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .skip_event(skip_event), .stall(stall),
      .skip_req(skip_req), .got(got), .word(word)
   );
   // ----
   // Scoreboard: an unexpected word is compared against its own inverse
   // ----
   always @(posedge clk) begin
      if (got === 1'b1) begin
         note = exp_q.size() != 0 ? exp_q.pop_front() :
                {32'hFFFFFFFF, ~word};
         `CHK(word & note[63:32], note[31:0])
      end
   end
   // ----
   // Helpers
   // ----
   task automatic test_done();
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic newfine();
      for (int i = 0; i < 12; i++) hit_fine[32*i+:32] = $random(seed);
      cf = 4'($random(seed));
   endtask
   task automatic fire();
      common_fine = cf;
      common_in = 1'b1;
      cyc(1);
      common_in = 1'b0;
   endtask
   task automatic settle();
      int i;
      i = 0;
      cyc(2);
      while (available !== 1'b1 && events_stored !== 3'd7 && i < 3000) begin
         cyc(1);
         i++;
      end
      if (i == 3000) begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic drain();
      int i;
      i = 0;
      while (exp_q.size() != 0 && i < 5000) begin
         cyc(1);
         i++;
      end
      if (i == 5000) begin
         bad_count++;
         test_done();
      end
   endtask
   function automatic void hdr(input int n);
      exp_q.push_back({32'hFFFFFFFF, 1'b1, tag, 17'h0, n[10:0]});
      tag = tag + 3'd1;
   endfunction
   function automatic void dat(input int c, input logic e,
                               input logic [15:0] d);
      exp_q.push_back({32'hFFFFFFFF, 1'b0, c[6:0], 7'h0, e, d});
   endfunction
   // Hit time against the common time, k clocks of 16 counts apart
   function automatic logic [15:0] dt(input int c, input int k);
      logic [15:0] h;
      h = {12'h0, hit_fine[4*c+:4]};
      if (mode == MODE_COMMON_STOP) return 16'(16 * k) + {12'h0, cf} - h;
      return 16'(16 * k) - {12'h0, cf} + h;
   endfunction
   // ----
   // Main sequence
   // ----
   initial begin
      seed = 32'h1c1692c8;
      rstn = 1'b0;
      hit_in = '0;
      hit_fine = '0;
      cf = 4'h0;
      common_fine = 4'h0;
      {common_in, time_out, fast_clear, ext_time_out} = 4'h0;
      mode = MODE_COMMON_START;
      edge_mode = EDGE_RISING;
      lifo_depth = 5'h10;
      full_scale = 13'h28;
      clear_window = 10'h1;
      {test_enable, test_go, stall, skip_req} = 4'h0;
      test_cycles = 2'h0;
      test_period = 2'h0;
      tag = 3'h0;
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      newfine();
      fire();
      hit_in[40] = 1'b1;
      cyc(2);
      hit_in[3] = 1'b1;
      cyc(2);
      hit_in[3] = 1'b0;
      cyc(2);
      hit_in[3] = 1'b1;
      cyc(1);
      hit_in = '0;
      hdr(3);
      dat(3, 1'b0, dt(3, 7));
      dat(3, 1'b0, dt(3, 3));
      dat(40, 1'b0, dt(40, 1));
      settle();
      for (int e = 0; e < 3; e++) begin
         edge_mode = mtc_edge_type'(e);
         newfine();
         fire();
         hit_in[95] = 1'b1;
         cyc(3);
         hit_in[95] = 1'b0;
         hdr(e == 2 ? 2 : 1);
         if (e != 0) dat(95, 1'b1, dt(95, 4));
         if (e != 1) dat(95, 1'b0, dt(95, 1));
         settle();
      end
      // Stop mode: depth two keeps the newest pair, limit is 320 counts
      mode = MODE_COMMON_STOP;
      edge_mode = EDGE_RISING;
      lifo_depth = 5'h2;
      full_scale = 13'h14;
      newfine();
      hit_fine[36+:4] = cf;
      hit_fine[40+:4] = cf;
      hit_in[7] = 1'b1;
      cyc(2);
      hit_in[7] = 1'b0;
      cyc(7);
      hit_in[10] = 1'b1;
      cyc(1);
      hit_in[9] = 1'b1;
      cyc(2);
      hit_in = '0;
      cyc(8);
      hit_in[7] = 1'b1;
      cyc(2);
      hit_in[7] = 1'b0;
      cyc(3);
      hit_in[7] = 1'b1;
      cyc(2);
      hit_in[7] = 1'b0;
      cyc(3);
      fire();
      hdr(3);
      dat(7, 1'b0, dt(7, 5));
      dat(7, 1'b0, dt(7, 10));
      dat(9, 1'b0, dt(9, 20));
      settle();
      mode = MODE_COMMON_START;
      lifo_depth = 5'h10;
      ext_time_out = 1'b1;
      full_scale = 13'h1000;
      newfine();
      fire();
      hit_in[20] = 1'b1;
      cyc(2);
      time_out = 1'b1;
      cyc(1);
      time_out = 1'b0;
      hit_in[20] = 1'b0;
      cyc(2);
      hit_in[20] = 1'b1;
      cyc(1);
      hit_in[20] = 1'b0;
      hdr(1);
      dat(20, 1'b0, dt(20, 1));
      settle();
      ext_time_out = 1'b0;
      full_scale = 13'hA;
      fire();
      hit_in[1] = 1'b1;
      cyc(20);
      hit_in[1] = 1'b0;
      fast_clear = 1'b1;
      cyc(2);
      fast_clear = 1'b0;
      settle();
      // Test pulse event under stall, then skip what has not reached the FIFO
      mode = MODE_COMMON_STOP;
      full_scale = 13'h64;
      stall = 1'b1;
      test_enable = 1'b1;
      test_go = 1'b1;
      cyc(1);
      test_go = 1'b0;
      cyc(40);
      fire();
      settle();
      test_enable = 1'b0;
      hdr(96);
      for (int c = 0; c < 7; c++)
         exp_q.push_back({32'hFFFF0000, 8'(c), 24'h0});
      cyc(20);
      skip_req = 1'b1;
      cyc(1);
      skip_req = 1'b0;
      fire();
      settle();
      hdr(0);
      stall = 1'b0;
      drain();
      mode = MODE_COMMON_START;
      full_scale = 13'h4;
      stall = 1'b1;
      for (int n = 0; n < 7; n++) begin
         newfine();
         fire();
         hit_in[9:0] = '1;
         cyc(1);
         hit_in = '0;
         hdr(10);
         for (int c = 0; c < 10; c++) dat(c, 1'b0, dt(c, 1));
         settle();
      end
      `CHK(events_stored, 3'd7)
      `CHK(available, 1'b0)
      fire();
      cyc(5);
      `CHK(events_stored, 3'd7)
      `CHK(busy, 1'b1)
      stall = 1'b0;
      drain();
      cyc(20);
      `CHK(events_stored, 3'd0)
      `CHK(busy, 1'b0)
      test_done();
   end
endmodule
